// file: src/see_pkg.sv
`default_nettype none
package see_pkg;
	// Slave address layout
	localparam logic [3:0] DEV_TYPE   = 4'ha;
	localparam int         MEM_ADDR_W = 11;
	localparam int         PAGE_BITS  = 4;
	localparam int         FIFO_DEPTH = 16;
	localparam logic [7:0] ERASED     = 8'hff;
	localparam logic [3:0] BYTE_BITS  = 4'h8;
	// Internal write cycle time
	localparam int unsigned CLK_HZ    = 100_000_000;
	localparam int unsigned T_WR_MS   = 5;
	localparam int unsigned T_WR_CYC  = T_WR_MS * (CLK_HZ / 1000);

	// Bus engine states, Gray along the usual path
	typedef enum logic [3:0] {
		SEE_IDLE   = 4'h0,
		SEE_DEV    = 4'h1,
		SEE_ACKDEV = 4'h3,
		SEE_WORD   = 4'h2,
		SEE_ACKWRD = 4'h6,
		SEE_WRDATA = 4'h7,
		SEE_ACKDAT = 4'h5,
		SEE_RDDATA = 4'h4,
		SEE_RDACK  = 4'hc
	} see_state_e;
endpackage
`default_nettype wire

// file: src/see_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module see_fifo #(
	parameter int W = 19,
	parameter int D = 16
) (
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
	} see_fifo_s;

	see_fifo_s st;
	see_fifo_s next_st;
	logic      push;
	logic      pop;

	// Handshake terms
	assign in_ready  = (st.cnt != (AW+1)'(D));
	assign out_valid = (st.cnt != '0);
	assign out_data  = st.mem[st.rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Pointer and count update
	always_comb begin
		next_st = st;
		if (push) begin
			next_st.mem[st.wp] = in_data;
			next_st.wp = st.wp + 1'b1;
		end
		if (pop) begin
			next_st.rp = st.rp + 1'b1;
		end
		if (push && !pop) begin
			next_st.cnt = st.cnt + 1'b1;
		end else if (pop && !push) begin
			next_st.cnt = st.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule
`default_nettype wire

// file: src/see_eeprom.sv
`timescale 1ns/100ps
`default_nettype none
module see_eeprom
	import see_pkg::*;
#(
	parameter int          ADDR_W  = see_pkg::MEM_ADDR_W,
	parameter int unsigned WR_CYC  = see_pkg::T_WR_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic [2:0] addr_pin,
	input  wire logic       wp,
	output logic            busy
);
	import see_pkg::*;

	localparam int NBYTES = 1 << ADDR_W;
	localparam int FW     = ADDR_W + 8;

	typedef struct packed {
		logic [NBYTES-1:0][7:0] mem;
		logic                   scl_m;
		logic                   scl_s;
		logic                   scl_p;
		logic                   sda_m;
		logic                   sda_s;
		logic                   sda_p;
		see_state_e             state;
		logic [3:0]             bitc;
		logic [7:0]             shreg;
		logic [7:0]             devb;
		logic [ADDR_W-1:0]      ptr;
		logic                   oe;
		logic                   sda_lvl;
		logic                   wp_lat;
		logic                   first;
		logic                   wr_pend;
		logic                   wbusy;
		logic [31:0]            wcnt;
		logic                   push_v;
		logic [FW-1:0]          push_d;
	} see_eeprom_s;

	see_eeprom_s     st;
	see_eeprom_s     next_st;
	logic            f_ready;
	logic            f_ovalid;
	logic [FW-1:0]   f_odata;
	logic            start_c;
	logic            stop_c;
	logic            rise;
	logic            fall;

	// Device address match: type nibble plus pins not used as address
	function automatic logic dev_match(input logic [7:0] b, input logic [2:0] pins);
		logic ok;
		ok = (b[7:4] == DEV_TYPE);
		for (int i = 0; i < 3; i++) begin
			if ((8 + i) >= ADDR_W && b[i+1] != pins[i]) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction

	// Full array address from address byte high bits and low byte
	function automatic logic [ADDR_W-1:0] mk_addr(input logic [7:0] dev, input logic [7:0] lo);
		logic [10:0] t;
		t = {dev[3:1], lo};
		return t[ADDR_W-1:0];
	endfunction

	// Page buffer between bus and array
	see_fifo #(
		.W (FW),
		.D (FIFO_DEPTH)
	) see_fifo_i (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (st.push_v),
		.in_ready  (f_ready),
		.in_data   (st.push_d),
		.out_valid (f_ovalid),
		.out_ready (st.wbusy),
		.out_data  (f_odata)
	);

	// Bus conditions from synchronised lines
	assign start_c = st.scl_s && st.scl_p && st.sda_p && !st.sda_s;
	assign stop_c  = st.scl_s && st.scl_p && !st.sda_p && st.sda_s;
	assign rise    = st.scl_s && !st.scl_p;
	assign fall    = !st.scl_s && st.scl_p;

	assign sda_out = st.sda_lvl;
	assign sda_oe  = st.oe;
	assign busy    = st.wbusy;

	// Next-state logic
	always_comb begin
		next_st = st;
		next_st.scl_m = scl;
		next_st.scl_s = st.scl_m;
		next_st.scl_p = st.scl_s;
		next_st.sda_m = sda_in;
		next_st.sda_s = st.sda_m;
		next_st.sda_p = st.sda_s;
		next_st.push_v = 1'b0;

		// Internal write cycle: drain page buffer while counting out
		if (st.wbusy) begin
			if (f_ovalid) begin
				next_st.mem[f_odata[FW-1:8]] = f_odata[7:0];
			end
			if (st.wcnt <= 32'h1 && !f_ovalid) begin
				next_st.wbusy = 1'b0;
				next_st.wcnt = '0;
			end else if (st.wcnt > 32'h1) begin
				next_st.wcnt = st.wcnt - 32'h1;
			end
		end

		if (start_c) begin
			next_st.state = SEE_DEV;
			next_st.bitc = '0;
			next_st.oe = 1'b0;
		end else if (stop_c) begin
			next_st.state = SEE_IDLE;
			next_st.oe = 1'b0;
			if (st.wr_pend && !st.wbusy) begin
				next_st.wbusy = 1'b1;
				next_st.wcnt = WR_CYC;
			end
			next_st.wr_pend = 1'b0;
		end else if (rise) begin
			case (st.state)
				SEE_DEV, SEE_WORD, SEE_WRDATA: begin
					next_st.shreg = {st.shreg[6:0], st.sda_s};
					next_st.bitc = st.bitc + 4'h1;
				end
				SEE_RDDATA: begin
					next_st.shreg = {st.shreg[6:0], 1'b0};
					next_st.bitc = st.bitc + 4'h1;
				end
				SEE_RDACK: begin
					if (st.sda_s) begin
						next_st.state = SEE_IDLE;
					end
				end
				default: begin
				end
			endcase
		end else if (fall) begin
			case (st.state)
				SEE_DEV: begin
					if (st.bitc == BYTE_BITS) begin
						next_st.bitc = '0;
						if (dev_match(st.shreg, addr_pin) && !st.wbusy) begin
							next_st.devb = st.shreg;
							next_st.oe = 1'b1;
							next_st.state = SEE_ACKDEV;
						end else begin
							next_st.state = SEE_IDLE;
						end
					end
				end
				SEE_ACKDEV: begin
					next_st.bitc = '0;
					if (st.devb[0]) begin
						next_st.ptr = mk_addr(st.devb, st.ptr[7:0]);
						next_st.shreg = st.mem[mk_addr(st.devb, st.ptr[7:0])];
						next_st.oe = ~st.mem[mk_addr(st.devb, st.ptr[7:0])][7];
						next_st.state = SEE_RDDATA;
					end else begin
						next_st.oe = 1'b0;
						next_st.state = SEE_WORD;
					end
				end
				SEE_WORD: begin
					if (st.bitc == BYTE_BITS) begin
						next_st.bitc = '0;
						next_st.ptr = mk_addr(st.devb, st.shreg);
						next_st.oe = 1'b1;
						next_st.state = SEE_ACKWRD;
					end
				end
				SEE_ACKWRD: begin
					next_st.wp_lat = wp;
					next_st.first = 1'b1;
					next_st.oe = 1'b0;
					next_st.state = SEE_WRDATA;
				end
				SEE_WRDATA: begin
					if (st.bitc == BYTE_BITS) begin
						next_st.bitc = '0;
						if ((st.first && st.wp_lat) || !f_ready) begin
							next_st.state = SEE_IDLE;
						end else begin
							next_st.push_v = 1'b1;
							next_st.push_d = {st.ptr, st.shreg};
							next_st.ptr[PAGE_BITS-1:0] = st.ptr[PAGE_BITS-1:0] + 1'b1;
							next_st.wr_pend = 1'b1;
							next_st.oe = 1'b1;
							next_st.state = SEE_ACKDAT;
						end
					end
				end
				SEE_ACKDAT: begin
					next_st.first = 1'b0;
					next_st.oe = 1'b0;
					next_st.state = SEE_WRDATA;
				end
				SEE_RDDATA: begin
					if (st.bitc == BYTE_BITS) begin
						next_st.oe = 1'b0;
						next_st.ptr = st.ptr + 1'b1;
						next_st.state = SEE_RDACK;
					end else begin
						next_st.oe = ~st.shreg[7];
					end
				end
				SEE_RDACK: begin
					next_st.bitc = '0;
					next_st.shreg = st.mem[st.ptr];
					next_st.oe = ~st.mem[st.ptr][7];
					next_st.state = SEE_RDDATA;
				end
				default: begin
					next_st.oe = 1'b0;
				end
			endcase
		end
	end

	// State register, array erased at reset
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
			st.mem <= {NBYTES{ERASED}};
			st.scl_m <= 1'b1;
			st.scl_s <= 1'b1;
			st.scl_p <= 1'b1;
			st.sda_m <= 1'b1;
			st.sda_s <= 1'b1;
			st.sda_p <= 1'b1;
			st.state <= SEE_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Checks
	property p_busy_nack;
		@(posedge clk_sys) disable iff (!rstn)
		(fall && !start_c && !stop_c && st.state == SEE_DEV && st.bitc == BYTE_BITS && st.wbusy)
			|=> (!st.oe && st.state == SEE_IDLE);
	endproperty
	a_busy_nack: assert property (p_busy_nack) else $error("address acked while busy");

	property p_ready_ack;
		@(posedge clk_sys) disable iff (!rstn)
		(fall && !start_c && !stop_c && st.state == SEE_DEV && st.bitc == BYTE_BITS
			&& !st.wbusy && dev_match(st.shreg, addr_pin))
			|=> (st.oe && st.state == SEE_ACKDEV);
	endproperty
	a_ready_ack: assert property (p_ready_ack) else $error("matching address not acked");

	property p_wp_sample;
		@(posedge clk_sys) disable iff (!rstn)
		(fall && !start_c && !stop_c && st.state == SEE_ACKWRD) |=> (st.wp_lat == $past(wp));
	endproperty
	a_wp_sample: assert property (p_wp_sample) else $error("protect not sampled");

	property p_wp_reject;
		@(posedge clk_sys) disable iff (!rstn)
		(fall && !start_c && !stop_c && st.state == SEE_WRDATA && st.bitc == BYTE_BITS
			&& st.first && st.wp_lat) |=> (!st.oe && !st.push_v && st.state == SEE_IDLE);
	endproperty
	a_wp_reject: assert property (p_wp_reject) else $error("protected byte accepted");

	property p_wr_start;
		@(posedge clk_sys) disable iff (!rstn)
		(stop_c && st.wr_pend && !st.wbusy) |=> (st.wbusy && st.wcnt == WR_CYC);
	endproperty
	a_wr_start: assert property (p_wr_start) else $error("write cycle not started");

	property p_wr_end;
		@(posedge clk_sys) disable iff (!rstn)
		(st.wbusy && st.wcnt == 32'h1 && !f_ovalid) |=> !st.wbusy ##1 !st.wbusy;
	endproperty
	a_wr_end: assert property (p_wr_end) else $error("busy outlived counter");

	property p_seq_inc;
		@(posedge clk_sys) disable iff (!rstn)
		(fall && !start_c && !stop_c && st.state == SEE_RDDATA && st.bitc == BYTE_BITS)
			|=> (st.ptr == $past(st.ptr) + 1'b1 && st.state == SEE_RDACK && !st.oe);
	endproperty
	a_seq_inc: assert property (p_seq_inc) else $error("read pointer not advanced");

	property p_page_wrap;
		@(posedge clk_sys) disable iff (!rstn)
		st.push_v |-> (st.ptr[ADDR_W-1:PAGE_BITS] == st.push_d[FW-1:8+PAGE_BITS]);
	endproperty
	a_page_wrap: assert property (p_page_wrap) else $error("page bits moved");

	property p_rd_nack;
		@(posedge clk_sys) disable iff (!rstn)
		(rise && !start_c && !stop_c && st.state == SEE_RDACK && st.sda_s) |=> (st.state == SEE_IDLE && !st.oe);
	endproperty
	a_rd_nack: assert property (p_rd_nack) else $error("read not ended on nack");

	c_poll_nack: cover property (@(posedge clk_sys) disable iff (!rstn)
		st.wbusy && st.state == SEE_DEV ##[1:1000] st.state == SEE_IDLE);
	c_seq_read:  cover property (@(posedge clk_sys) disable iff (!rstn)
		st.state == SEE_RDACK ##[1:1000] st.state == SEE_RDDATA);
	c_wp_block:  cover property (@(posedge clk_sys) disable iff (!rstn)
		st.state == SEE_WRDATA && st.wp_lat && fall && st.bitc == BYTE_BITS);
endmodule
`default_nettype wire

// file: tb/see_master.sv
`timescale 1ns/100ps
`default_nettype none
module see_master #(
	parameter int H = 8
) (
	input  wire logic clk_sys,
	input  wire logic sda_oe,
	output logic      scl,
	output logic      master_oe,
	output wire logic sda
);
	// Open-drain wire with pull-up, either party pulls low
	assign sda = !(master_oe | sda_oe);

	// Bus idles with both lines released
	initial begin
		scl = 1'b1;
		master_oe = 1'b0;
	end

	// Wait n clocks, then move just after the edge
	task automatic hold(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// START or repeated START, SCL left low
	task automatic start();
		hold(H / 2);
		master_oe = 1'b0;
		hold(H);
		scl = 1'b1;
		hold(H);
		master_oe = 1'b1;
		hold(H);
		scl = 1'b0;
	endtask

	// One bit: data changes mid-low, sampled late in high
	task automatic bit_io(input logic b, output logic r);
		hold(H / 2);
		master_oe = !b;
		hold(H / 2);
		scl = 1'b1;
		hold(H);
		r = sda;
		scl = 1'b0;
	endtask

	// Byte out MSB first, returns the device acknowledge
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask

	// Byte in MSB first, acknowledged only when more is wanted
	task automatic get_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 0; i < 8; i++) begin
			bit_io(1'b1, r);
			d = {d[6:0], r};
		end
		bit_io(!more, r);
	endtask

	// STOP: SDA rises while SCL is high
	task automatic stop();
		hold(H / 2);
		master_oe = 1'b1;
		hold(H / 2);
		scl = 1'b1;
		hold(H);
		master_oe = 1'b0;
		hold(H);
	endtask
endmodule
`default_nettype wire

// file: tb/see_eeprom_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module see_eeprom_tb_top;
	import see_pkg::*;
	localparam int unsigned WR   = 400;
	localparam logic [2:0]  PINS = 3'h5;
	logic       clk_sys;
	logic       rstn;
	logic       wp;
	logic [2:0] addr_pin;
	logic       scl;
	logic       master_oe;
	logic       sda_out;
	logic       sda_oe;
	logic       busy;
	logic       a;
	logic [7:0] d;
	wire        sda;
	int         fails;
	int         total_checks;

	see_eeprom #(.ADDR_W(8), .WR_CYC(WR)) see_eeprom_i (.clk_sys(clk_sys), .rstn(rstn),
		.scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.addr_pin(addr_pin), .wp(wp), .busy(busy));
	see_master see_master_i (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl(scl),
		.master_oe(master_oe), .sda(sda));

	// 100 MHz clock
	initial clk_sys = 1'b0;
	always #5 clk_sys = !clk_sys;

	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Counts, verdict, end of run
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// START plus address byte with our pins
	task automatic dev(input logic rd);
		see_master_i.start();
		see_master_i.put_byte({DEV_TYPE, PINS, rd}, a);
	endtask

	// Dummy write that loads the pointer
	task automatic point(input logic [7:0] wa);
		dev(1'b0);
		check(8'(a), 8'h01);
		see_master_i.put_byte(wa, a);
		check(8'(a), 8'h01);
	endtask

	// Random read opening: pointer load, repeated START, read address
	task automatic rd_open(input logic [7:0] wa);
		point(wa);
		dev(1'b1);
		check(8'(a), 8'h01);
	endtask

	// Write n bytes from the top of data, then STOP
	task automatic wr_n(input logic [7:0] wa, input logic [31:0] data, input int n);
		point(wa);
		for (int i = 0; i < n; i++) begin
			see_master_i.put_byte(data[31-8*i -: 8], a);
			check(8'(a), 8'h01);
		end
		see_master_i.stop();
		check(8'(busy), 8'h01);
	endtask

	// Acknowledge polling right after the write STOP
	task automatic poll();
		int k;
		k = 0;
		dev(1'b0);
		see_master_i.stop();
		check(8'(a), 8'h00);
		while (a !== 1'b1 && k < 20) begin
			dev(1'b0);
			see_master_i.stop();
			k++;
		end
		check(8'(a), 8'h01);
		check(8'(busy), 8'h00);
	endtask

	task automatic t_erased();
		rd_open(8'h10);
		see_master_i.get_byte(1'b0, d);
		check(d, ERASED);
		see_master_i.stop();
		check(8'(sda_oe), 8'h00);
		$display("test erased done");
	endtask

	task automatic t_page_poll();
		wr_n(8'h0e, 32'ha1a2a3a4, 4);
		poll();
		rd_open(8'h0e);
		see_master_i.get_byte(1'b1, d);
		check(d, 8'ha1);
		see_master_i.get_byte(1'b1, d);
		check(d, 8'ha2);
		see_master_i.get_byte(1'b0, d);
		check(d, ERASED);
		see_master_i.stop();
		rd_open(8'h00);
		see_master_i.get_byte(1'b1, d);
		check(d, 8'ha3);
		see_master_i.get_byte(1'b0, d);
		check(d, 8'ha4);
		see_master_i.stop();
		$display("test page and poll done");
	endtask

	task automatic t_wrap();
		wr_n(8'hff, 32'h5a000000, 1);
		poll();
		rd_open(8'hff);
		see_master_i.get_byte(1'b1, d);
		check(d, 8'h5a);
		see_master_i.get_byte(1'b0, d);
		check(d, 8'ha3);
		see_master_i.stop();
		dev(1'b1);
		check(8'(a), 8'h01);
		see_master_i.get_byte(1'b0, d);
		check(d, 8'ha4);
		see_master_i.stop();
		$display("test wrap done");
	endtask

	// Protect moves only after the sampling fall, so the latched level decides
	task automatic t_protect();
		wp = 1'b1;
		point(8'h20);
		see_master_i.hold(4);
		wp = 1'b0;
		see_master_i.put_byte(8'h55, a);
		check(8'(a), 8'h00);
		see_master_i.stop();
		check(8'(busy), 8'h00);
		rd_open(8'h20);
		see_master_i.get_byte(1'b0, d);
		check(d, ERASED);
		see_master_i.stop();
		point(8'h30);
		see_master_i.hold(4);
		wp = 1'b1;
		see_master_i.put_byte(8'h66, a);
		check(8'(a), 8'h01);
		see_master_i.stop();
		check(8'(busy), 8'h01);
		wp = 1'b0;
		poll();
		rd_open(8'h30);
		see_master_i.get_byte(1'b0, d);
		check(d, 8'h66);
		see_master_i.stop();
		$display("test protect done");
	endtask

	task automatic t_wrong();
		see_master_i.start();
		see_master_i.put_byte({DEV_TYPE, ~PINS, 1'b0}, a);
		check(8'(a), 8'h00);
		see_master_i.start();
		see_master_i.put_byte({4'h5, PINS, 1'b1}, a);
		check(8'(a), 8'h00);
		see_master_i.stop();
		addr_pin = 3'h2;
		see_master_i.start();
		see_master_i.put_byte({DEV_TYPE, 3'h2, 1'b0}, a);
		check(8'(a), 8'h01);
		see_master_i.stop();
		addr_pin = PINS;
		$display("test address select done");
	endtask

	// Reset in mid write cycle: outputs released, array back to erased
	task automatic t_reset();
		wr_n(8'h40, 32'h3c000000, 1);
		rstn = 1'b0;
		see_master_i.hold(2);
		check(8'(busy), 8'h00);
		check(8'(sda_oe), 8'h00);
		check(8'(sda_out), 8'h00);
		rstn = 1'b1;
		see_master_i.hold(4);
		rd_open(8'h40);
		see_master_i.get_byte(1'b0, d);
		check(d, ERASED);
		check(8'(sda_out), 8'h00);
		see_master_i.stop();
		$display("test reset done");
	endtask

	// Main sequence
	initial begin
		fails = 0;
		total_checks = 0;
		rstn = 1'b0;
		wp = 1'b0;
		addr_pin = PINS;
		repeat (16) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		t_erased();
		t_page_poll();
		t_wrap();
		t_protect();
		t_wrong();
		t_reset();
		summarize();
	end

	// Watchdog, well beyond the expected run length
	initial begin
		#500_000;
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
